// ### core/linreg_ctrl_regs.vh
// Register map and field layout of the linear regulator control bank.
// Assumes APB with 32-bit data; each register takes one aligned word.
`ifndef LINREG_CTRL_REGS_VH
`define LINREG_CTRL_REGS_VH

// =============================================================
// Register indices (printed offsets) and byte addresses
`define LINREG7_IDX 8'h2c
`define LINREG8_IDX 8'h2d
`define LINREG9_IDX 8'h2e
`define LINREG10_IDX 8'h2f
`define LINREG_ADDR_W 12
`define LINREG7_ADDR 12'h0b0
`define LINREG8_ADDR 12'h0b4
`define LINREG9_ADDR 12'h0b8
`define LINREG10_ADDR 12'h0bc
`define LINREG_STATE_ADDR 12'h0c0

// =============================================================
// Field positions
`define F_ENABLE 0
`define F_ENSRC_LO 1
`define F_ENSRC_HI 2
`define F_PD_OFF 3
`define F_VPICK 4
`define F_VSRC_LO 5
`define F_VSRC_HI 6
`define F_SEQ_TGT 7

// =============================================================
// Source codes and reset value
`define SRC_SEQ 2'h0
`define SRC_GP_ONE 2'h1
`define SRC_GP_TWO 2'h2
`define SRC_GP_THIRTEEN 2'h3
`define LINREG_RESET 8'h00

`endif

// ### core/linreg_ctrl.v
// Control register bank for four linear regulators (seven to ten).
// Assumes an APB master on i_sys_clk and GP inputs synchronous to it.
`timescale 1ns/10ps
`include "linreg_ctrl_regs.vh"

// Notes on behaviour
// - Bit 0 turns a regulator off at 0 and on at 1.
// - Bit 7 is the enable state the sequencer applies when it runs.
// - Bits 2:1 pick the enable source: sequencer, or GP one, two, 13.
// - A named GP input switches the regulator on going passive to active.
// - A named GP input switches the regulator off going active to passive.
// - Bits 6:5 use the same codes; passive to active picks setting A.
// - Under GP voltage control active to passive picks B, no ramp.
// - Bit 4 picks setting A at 0 or B at 1, applied at once.
// - Bit 3 at 0 connects the pull-down of a disabled output, 1 does not.
module linreg_ctrl (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output wire o_pslverr,
  // Power state and sequencer
  input wire i_active_state,
  input wire i_seq_run,
  // General purpose inputs
  input wire i_gp_input_one,
  input wire i_gp_input_two,
  input wire i_gp_input_thirteen,
  // Regulator controls, bit n-7 for regulator n
  output reg [3:0] o_reg_enable,
  output reg [3:0] o_reg_voltage_b,
  output reg [3:0] o_reg_pulldown_on
);

// =============================================================
// Bus decode
wire wr_go = i_psel & i_penable & i_pwrite & i_pstrb[0];
wire rd_go = i_psel & i_penable & ~i_pwrite;
wire [3:0] hit;
wire hit_state = (i_paddr == `LINREG_STATE_ADDR);
wire mapped = (|hit) | hit_state;
assign hit[0] = (i_paddr == `LINREG7_ADDR);
assign hit[1] = (i_paddr == `LINREG8_ADDR);
assign hit[2] = (i_paddr == `LINREG9_ADDR);
assign hit[3] = (i_paddr == `LINREG10_ADDR);
// Zero wait states; unmapped addresses answer with an error
assign o_pready = 1'b1;
assign o_pslverr = i_psel & i_penable & ~mapped;

// =============================================================
// Power state edge detection
reg active_q;
wire go_active = i_active_state & ~active_q;
wire go_passive = ~i_active_state & active_q;
always @(posedge i_sys_clk) begin
  if (i_rst) begin
    active_q <= 1'b0;
  end else begin
    active_q <= i_active_state;
  end
end

// Selected GP level per code; code 0 is unused
function gp_level;
  input [1:0] code;
  begin
    if (code == `SRC_GP_ONE) begin
      gp_level = i_gp_input_one;
    end else if (code == `SRC_GP_TWO) begin
      gp_level = i_gp_input_two;
    end else begin
      gp_level = i_gp_input_thirteen;
    end
  end
endfunction

// =============================================================
// Per regulator control register and outputs
wire [7:0] ctrl [0:3];
wire [3:0] next_enable;
wire [3:0] next_voltage_b;
wire [3:0] next_pulldown_on;
genvar g;
generate
  for (g = 0; g < 4; g = g + 1) begin : reg_slice
    reg [7:0] cr;
    wire [1:0] ensrc = cr[`F_ENSRC_HI:`F_ENSRC_LO];
    wire [1:0] vsrc = cr[`F_VSRC_HI:`F_VSRC_LO];
    // GP gated transitions, taken only while the GP input is high
    wire en_gp = (ensrc != `SRC_SEQ) & gp_level(ensrc);
    wire v_gp = (vsrc != `SRC_SEQ) & gp_level(vsrc);
    assign ctrl[g] = cr;
    always @(posedge i_sys_clk) begin
      if (i_rst) begin
        cr <= `LINREG_RESET;
      end else if (wr_go && hit[g]) begin
        // Bus write wins over a same-cycle hardware update
        cr <= i_pwdata[7:0];
      end else begin
        if (ensrc == `SRC_SEQ && i_seq_run) begin
          cr[`F_ENABLE] <= cr[`F_SEQ_TGT];
        end else if (en_gp && go_active) begin
          cr[`F_ENABLE] <= 1'b1;
        end else if (en_gp && go_passive) begin
          cr[`F_ENABLE] <= 1'b0;
        end
        if (v_gp && go_active) begin
          cr[`F_VPICK] <= 1'b0;
        end else if (v_gp && go_passive) begin
          cr[`F_VPICK] <= 1'b1;
        end
      end
    end
    // Outputs follow the stored bits; no ramping of the voltage pick
    assign next_enable[g] = cr[`F_ENABLE];
    assign next_voltage_b[g] = cr[`F_VPICK];
    assign next_pulldown_on[g] = ~cr[`F_ENABLE] & ~cr[`F_PD_OFF];
  end
endgenerate

// =============================================================
// Output flops, one process so each vector has a single driver
always @(posedge i_sys_clk) begin
  if (i_rst) begin
    o_reg_enable <= 4'h0;
    o_reg_voltage_b <= 4'h0;
    o_reg_pulldown_on <= 4'hf;
  end else begin
    o_reg_enable <= next_enable;
    o_reg_voltage_b <= next_voltage_b;
    o_reg_pulldown_on <= next_pulldown_on;
  end
end

// =============================================================
// Read data, registered during the setup phase
always @(posedge i_sys_clk) begin
  if (i_rst) begin
    o_prdata <= 32'h0000_0000;
  end else if (i_psel && !i_penable && !i_pwrite) begin
    if (i_paddr == `LINREG7_ADDR) begin
      o_prdata <= {24'h00_0000, ctrl[0]};
    end else if (i_paddr == `LINREG8_ADDR) begin
      o_prdata <= {24'h00_0000, ctrl[1]};
    end else if (i_paddr == `LINREG9_ADDR) begin
      o_prdata <= {24'h00_0000, ctrl[2]};
    end else if (i_paddr == `LINREG10_ADDR) begin
      o_prdata <= {24'h00_0000, ctrl[3]};
    end else if (hit_state) begin
      o_prdata <= {20'h0_0000, o_reg_pulldown_on, o_reg_voltage_b,
        o_reg_enable};
    end else begin
      o_prdata <= 32'h0000_0000;
    end
  end
end

endmodule

// ### tb/linreg_ctrl_assertions.sv
// Checker on the regulator control bank ports.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/10ps
`include "linreg_ctrl_regs.vh"
module linreg_ctrl_chk (
  // Only the ports the properties watch
  input wire i_sys_clk, i_rst, i_psel, i_penable, i_pwrite, i_seq_run,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb,
  input wire o_pready, o_pslverr,
  input wire [31:0] o_prdata,
  input wire [3:0] o_reg_enable, o_reg_voltage_b, o_reg_pulldown_on
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Sequencer kept quiet so the written value reaches the outputs
  wire wr = i_psel & i_penable & i_pwrite & i_pstrb[0] & !i_seq_run;
  a_ready_high: assert property (o_pready)
    else $error("pready low");
  a_enable_write: assert property (wr && i_paddr == `LINREG8_ADDR
    |-> ##2 o_reg_enable[1] == $past(i_pwdata[0], 2)) else $error("enable");
  a_vpick_write: assert property (wr && i_paddr == `LINREG9_ADDR
    |-> ##2 o_reg_voltage_b[2] == $past(i_pwdata[4], 2)) else $error("vpick");
  a_pd_write: assert property (wr && i_paddr == `LINREG10_ADDR |-> ##2
    o_reg_pulldown_on[3] == !($past(i_pwdata[0], 2) | $past(i_pwdata[3], 2)))
    else $error("pulldown");
  a_pd_excl: assert property (!(|(o_reg_pulldown_on & o_reg_enable)))
    else $error("pulldown on enabled");
  a_err_unmapped: assert property (i_psel && i_penable
    && i_paddr == 12'h100 |-> o_pslverr) else $error("no slverr");
  a_err_mapped: assert property (i_psel && i_penable
    && i_paddr == `LINREG7_ADDR |-> !o_pslverr) else $error("slverr");
  a_rd_unmapped: assert property (i_psel && !i_penable && !i_pwrite
    && i_paddr == 12'h100 |=> o_prdata == 32'h0000_0000) else $error("rdata");
endmodule
bind linreg_ctrl linreg_ctrl_chk i_chk (.i_sys_clk, .i_rst, .i_psel,
  .i_penable, .i_pwrite, .i_seq_run, .i_paddr, .i_pwdata, .i_pstrb, .o_pready,
  .o_pslverr, .o_prdata, .o_reg_enable, .o_reg_voltage_b, .o_reg_pulldown_on);

// ### tb/linreg_ctrl_bench.sv
// Bench: APB traffic and power transitions against a register model.
// Assumes design and checker files compiled first.
`timescale 1ns/10ps
`include "linreg_ctrl_regs.vh"
module linreg_ctrl_bench;
  reg i_sys_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  reg i_active_state = 0, i_seq_run = 0, er;
  reg [11:0] i_paddr = 0;
  reg [31:0] i_pwdata = 0, rd;
  reg [3:0] i_pstrb = 0, s;
  reg [2:0] gp = 0;
  reg [7:0] m [0:3];
  reg [7:0] d;
  reg [11:0] st;
  wire o_pready, o_pslverr;
  wire [31:0] o_prdata;
  wire [3:0] en, vb, pd;
  integer error_cnt = 0, checks_done = 0, cyc = 0, i, j, k;
  always #20 i_sys_clk = ~i_sys_clk;
  linreg_ctrl i_linreg_ctrl (.i_sys_clk, .i_rst, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_pready, .o_prdata,
    .o_pslverr, .i_active_state, .i_seq_run, .i_gp_input_one(gp[0]),
    .i_gp_input_two(gp[1]), .i_gp_input_thirteen(gp[2]),
    .o_reg_enable(en), .o_reg_voltage_b(vb), .o_reg_pulldown_on(pd));
  // ==========================================
  // Checks and bus cycles
  task give_verdict;
    begin
      if (error_cnt == 0 && checks_done > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [63:0] n, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("BAD %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [7:0] dv, input [3:0] sv);
    begin
      @(posedge i_sys_clk);
      i_psel <= 1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= {24'h00_0000, dv};
      i_pstrb <= sv;
      @(posedge i_sys_clk);
      i_penable <= 1;
      @(posedge i_sys_clk);
      while (o_pready !== 1'b1) @(posedge i_sys_clk);
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 0;
      i_penable <= 0;
    end
  endtask
  task cmp_all;
    begin
      for (j = 0; j < 4; j = j + 1) begin
        apb(0, `LINREG7_ADDR + 4 * j, 8'h00, 4'h0);
        chk("reg", m[j], rd);
        chk("enable", m[j][0], en[j]);
        chk("vpick", m[j][4], vb[j]);
        chk("pulldown", !m[j][0] && !m[j][3], pd[j]);
        st[j] = m[j][0];
        st[4 + j] = m[j][4];
        st[8 + j] = !m[j][0] && !m[j][3];
      end
      apb(0, `LINREG_STATE_ADDR, 8'h00, 4'h0);
      chk("state", {20'h0_0000, st}, rd);
    end
  endtask
  // ==========================================
  // Hang guard, far above the expected run
  always @(posedge i_sys_clk) begin
    cyc = cyc + 1;
    if (cyc > 4000) begin
      error_cnt = error_cnt + 1;
      give_verdict;
    end
  end
  initial begin
    k = $urandom(5256);
    for (i = 0; i < 4; i = i + 1) m[i] = 8'h00;
    repeat (16) @(posedge i_sys_clk);
    i_rst <= 0;
    cmp_all;
    repeat (24) begin
      k = $urandom % 4;
      d = $urandom;
      s = $urandom;
      apb(1, `LINREG7_ADDR + 4 * k, d, s);
      if (s[0]) m[k] = d;
    end
    cmp_all;
    apb(1, 12'h100, 8'hff, 4'hf);
    apb(0, 12'h100, 8'h00, 4'h0);
    chk("unmapped", 0, rd);
    chk("slverr", 1, er);
    i_seq_run <= 1;
    repeat (4) @(posedge i_sys_clk);
    i_seq_run <= 0;
    for (i = 0; i < 4; i = i + 1) if (m[i][2:1] == 0) m[i][0] = m[i][7];
    cmp_all;
    for (k = 1; k < 4; k = k + 1) begin
      d = {1'b0, k[1:0], 2'b10, k[1:0], 1'b0};
      apb(1, `LINREG7_ADDR, d, 4'h1);
      m[0] = d;
      repeat (2) begin
        gp <= $urandom | (3'b001 << (k - 1));
        @(posedge i_sys_clk);
        i_active_state <= !i_active_state;
        repeat (3) @(posedge i_sys_clk);
        for (i = 0; i < 4; i = i + 1) begin
          if (m[i][2:1] != 0 && gp[m[i][2:1] - 1]) m[i][0] = i_active_state;
          if (m[i][6:5] != 0 && gp[m[i][6:5] - 1]) m[i][4] = !i_active_state;
        end
        cmp_all;
      end
    end
    give_verdict;
  end
endmodule
